// ---- ssc_ctrl.sv ----
// stop mode standby controller: sleep entry, clock gating, wake sequencing
`timescale 1ns/100ps
`default_nettype none
module ssc_ctrl (
  input wire logic CORE_CLK, // 200 MHz core clock
  input wire logic SYS_RST, // synchronous reset, active high
  input wire logic CLK_EN, // freezes all state while low
  input wire logic SLEEP_REQ, // sleep instruction executed, one-cycle pulse
  input wire logic [2:0] CPU_CLK_SRC, // current cpu clock source
  input wire logic IRQ_PENDING, // some unmasked interrupt is requesting
  input wire logic IRQ_ACK_EN, // cpu interrupt acknowledge enabled
  input wire logic SNOOZE_TRIG, // converter or serial channel 0 wake trigger
  input wire logic ADDR_MATCH, // two-wire unit own address match
  input wire logic [31:0] WB_ADR_I, // wishbone address
  input wire logic [31:0] WB_DAT_I, // wishbone write data
  input wire logic [3:0] WB_SEL_I, // wishbone byte selects
  input wire logic WB_WE_I, // wishbone write enable
  input wire logic WB_CYC_I, // wishbone cycle
  input wire logic WB_STB_I, // wishbone strobe
  output logic [31:0] WB_DAT_O, // wishbone read data
  output logic WB_ACK_O, // wishbone acknowledge
  output ssc_pkg::ssc_clk_t CLK_GATES, // oscillator and clock enables
  output ssc_pkg::ssc_periph_t PERIPH, // peripheral controls in sleep
  output logic SLEEPING, // any state but run: deep sleep, partial wake or wake sequence
  output logic RESUME_VEC, // pulse: take vectored interrupt
  output logic RESUME_NEXT // pulse: continue after sleep instruction
);
  ssc_pkg::ssc_state_t state_q;
  logic [7:0] ctrl_q;
  logic [ssc_pkg::CNT_W-1:0] osc_stab_time_select_q;
  logic [ssc_pkg::CNT_W-1:0] cnt_q;
  logic [ssc_pkg::CNT_W-1:0] off_len_q;
  logic [3:0] wait_q;
  logic vec_q;
  logic x1_q;
  logic entry_ok;
  logic wb_hit;

  function automatic logic main_src(input logic [2:0] s);
    main_src = (s == ssc_pkg::SRC_HOCO) || (s == ssc_pkg::SRC_X1) || (s == ssc_pkg::SRC_EXT);
  endfunction

  // pll must already be stopped, otherwise the clock source would be pll anyway
  assign entry_ok = main_src(CPU_CLK_SRC) && ctrl_q[ssc_pkg::CTRL_PLL_STOP];
  assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;

  // register bus; ack one cycle after request, dropped next cycle
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      ctrl_q <= ssc_pkg::CTRL_RST;
      osc_stab_time_select_q <= ssc_pkg::OSC_STAB_TIME_SELECT_RST;
    end else if (CLK_EN) begin
      WB_ACK_O <= wb_hit;
      if (wb_hit) begin
        WB_DAT_O <= 32'h0000_0000;
        if (WB_ADR_I[3:0] == ssc_pkg::ADR_CTRL) begin
          if (WB_WE_I && WB_SEL_I[0]) begin
            ctrl_q <= WB_DAT_I[7:0];
          end
          WB_DAT_O <= {24'h00_0000, ctrl_q};
        end else if (WB_ADR_I[3:0] == ssc_pkg::ADR_STAT) begin
          WB_DAT_O <= {28'h000_0000, x1_q, state_q};
        end else if (WB_ADR_I[3:0] == ssc_pkg::ADR_OSC_STAB_TIME_SELECT) begin
          if (WB_WE_I && WB_SEL_I[0]) begin
            osc_stab_time_select_q[7:0] <= WB_DAT_I[7:0];
          end
          if (WB_WE_I && WB_SEL_I[1]) begin
            osc_stab_time_select_q[15:8] <= WB_DAT_I[15:8];
          end
          WB_DAT_O <= {16'h0000, osc_stab_time_select_q};
        end
      end
    end
  end

  // sleep sequencer
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_q <= ssc_pkg::SSC_RUN;
      cnt_q <= '0;
      off_len_q <= '0;
      wait_q <= 4'h0;
      vec_q <= 1'b0;
      x1_q <= 1'b0;
      RESUME_VEC <= 1'b0;
      RESUME_NEXT <= 1'b0;
    end else if (CLK_EN) begin
      RESUME_VEC <= 1'b0;
      RESUME_NEXT <= 1'b0;
      case (state_q)
        ssc_pkg::SSC_RUN: begin
          if (SLEEP_REQ && entry_ok) begin
            x1_q <= (CPU_CLK_SRC == ssc_pkg::SRC_X1);
            // a pending interrupt goes straight to the release sequence
            state_q <= IRQ_PENDING ? ssc_pkg::SSC_CLKOFF : ssc_pkg::SSC_STOP;
            vec_q <= IRQ_ACK_EN;
            cnt_q <= '0;
            off_len_q <= ssc_pkg::CLK_OFF_MIN_CYC[ssc_pkg::CNT_W-1:0];
          end
        end
        ssc_pkg::SSC_STOP: begin
          if (IRQ_PENDING || ADDR_MATCH) begin
            state_q <= ssc_pkg::SSC_CLKOFF;
            vec_q <= IRQ_ACK_EN;
            cnt_q <= '0;
          end else if (SNOOZE_TRIG && (ctrl_q[ssc_pkg::CTRL_CONV_SNZ] || ctrl_q[ssc_pkg::CTRL_SER_SNZ])) begin
            state_q <= ssc_pkg::SSC_SNOOZE;
          end
        end
        ssc_pkg::SSC_SNOOZE: begin
          // unit work done without an interrupt drops back to sleep
          if (IRQ_PENDING) begin
            state_q <= ssc_pkg::SSC_CLKOFF;
            vec_q <= IRQ_ACK_EN;
            cnt_q <= '0;
          end else if (!SNOOZE_TRIG) begin
            state_q <= ssc_pkg::SSC_STOP;
          end
        end
        ssc_pkg::SSC_CLKOFF: begin
          cnt_q <= cnt_q + 1'b1;
          // crystal stretches to the stabilization setting when longer
          if (cnt_q + 1'b1 >= ((x1_q && osc_stab_time_select_q > off_len_q) ? osc_stab_time_select_q : off_len_q)) begin
            state_q <= ssc_pkg::SSC_WAIT;
            if (x1_q) begin
              wait_q <= vec_q ? ssc_pkg::WAIT_X1_VEC : ssc_pkg::WAIT_X1_NOVEC;
            end else begin
              wait_q <= vec_q ? ssc_pkg::WAIT_HOCO_VEC : ssc_pkg::WAIT_HOCO_NOVEC;
            end
          end
        end
        ssc_pkg::SSC_WAIT: begin
          wait_q <= wait_q - 1'b1;
          if (wait_q == 4'h1) begin
            state_q <= ssc_pkg::SSC_RUN;
            RESUME_VEC <= vec_q;
            RESUME_NEXT <= !vec_q;
          end
        end
        default: state_q <= ssc_pkg::SSC_RUN;
      endcase
    end
  end

  // clock gates and peripheral controls, registered
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      CLK_GATES <= '{cpu_clk_en: 1'b1, hoco_en: 1'b1, x1_en: 1'b1, ext_en: 1'b1, pll_en: 1'b1, lowspeed_en: 1'b1};
      PERIPH <= '0;
      SLEEPING <= 1'b0;
    end else if (CLK_EN) begin
      SLEEPING <= (state_q != ssc_pkg::SSC_RUN);
      CLK_GATES.cpu_clk_en <= (state_q == ssc_pkg::SSC_RUN);
      CLK_GATES.hoco_en <= (state_q == ssc_pkg::SSC_RUN) || (state_q == ssc_pkg::SSC_SNOOZE)
                           || (state_q == ssc_pkg::SSC_WAIT);
      CLK_GATES.x1_en <= (state_q == ssc_pkg::SSC_RUN) || (x1_q && state_q != ssc_pkg::SSC_STOP
                           && state_q != ssc_pkg::SSC_SNOOZE);
      CLK_GATES.ext_en <= (state_q == ssc_pkg::SSC_RUN) || (state_q == ssc_pkg::SSC_WAIT);
      CLK_GATES.pll_en <= (state_q == ssc_pkg::SSC_RUN) && !ctrl_q[ssc_pkg::CTRL_PLL_STOP];
      // subsystem clock untouched here: no gate for it leaves it as configured
      CLK_GATES.lowspeed_en <= (state_q == ssc_pkg::SSC_RUN) || ctrl_q[ssc_pkg::CTRL_WUT_CLK]
                               || (ctrl_q[ssc_pkg::CTRL_WDT_EN] && ctrl_q[ssc_pkg::CTRL_WDT_STBY]);
      PERIPH.latch_hold <= (state_q != ssc_pkg::SSC_RUN);
      PERIPH.auto_stop <= (state_q != ssc_pkg::SSC_RUN);
      PERIPH.buzzer_en <= (state_q == ssc_pkg::SSC_RUN)
                          || (ctrl_q[ssc_pkg::CTRL_BUZ_SUB] && !ctrl_q[ssc_pkg::CTRL_RTC_LP]);
      PERIPH.conv_wake_en <= (state_q != ssc_pkg::SSC_RUN) && ctrl_q[ssc_pkg::CTRL_CONV_SNZ];
      PERIPH.ser_ch0_wake_en <= (state_q != ssc_pkg::SSC_RUN) && ctrl_q[ssc_pkg::CTRL_SER_SNZ];
      PERIPH.ser_other_en <= (state_q == ssc_pkg::SSC_RUN);
      PERIPH.two_wire_wake_en <= (state_q == ssc_pkg::SSC_STOP);
    end
  end

  a_wait_to_resume: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_WAIT && wait_q == 4'h1) |=> (RESUME_VEC != RESUME_NEXT))
    else $error("resume pulse missing after wait");
  a_no_pll_entry: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_RUN && SLEEP_REQ && CPU_CLK_SRC == ssc_pkg::SRC_PLL)
    |=> state_q == ssc_pkg::SSC_RUN)
    else $error("sleep entered from pll clock");
  a_sleep_entry: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_RUN && SLEEP_REQ && entry_ok && !IRQ_PENDING)
    |=> state_q == ssc_pkg::SSC_STOP)
    else $error("sleep request not taken");
  a_pending_exit: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_RUN && SLEEP_REQ && entry_ok && IRQ_PENDING)
    |=> state_q == ssc_pkg::SSC_CLKOFF)
    else $error("pending interrupt did not release");
  a_cpu_gated: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_STOP) |=> !CLK_GATES.cpu_clk_en && !CLK_GATES.pll_en)
    else $error("cpu clock running in sleep");
  a_irq_wakes: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_STOP && IRQ_PENDING) |=> state_q == ssc_pkg::SSC_CLKOFF)
    else $error("interrupt did not end sleep");
  a_latch_hold: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_STOP) |=> PERIPH.latch_hold)
    else $error("latches not held in sleep");
  a_lowspeed_stop: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_STOP && !ctrl_q[ssc_pkg::CTRL_WUT_CLK] && !ctrl_q[ssc_pkg::CTRL_WDT_EN])
    |=> !CLK_GATES.lowspeed_en)
    else $error("low-speed oscillator not stopped");
  a_hoco_clkoff: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_CLKOFF && !x1_q && cnt_q == '0)
    |=> state_q == ssc_pkg::SSC_CLKOFF)
    else $error("clock-off interval too short");

  // sleep state: oscillators, peripherals, wake sources
  a_sub_refused: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_RUN && SLEEP_REQ && CPU_CLK_SRC == ssc_pkg::SRC_SUB)
    |=> state_q == ssc_pkg::SSC_RUN)
    else $error("sleep entered from subsystem clock");
  a_osc_stopped: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_STOP)
    |=> !CLK_GATES.hoco_en && !CLK_GATES.x1_en && !CLK_GATES.ext_en)
    else $error("main oscillator running in sleep");
  a_lowspeed_run: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_STOP && ctrl_q[ssc_pkg::CTRL_WUT_CLK])
    |=> CLK_GATES.lowspeed_en)
    else $error("low-speed oscillator stopped under wake timer");
  a_buzzer_off: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q != ssc_pkg::SSC_RUN && !(ctrl_q[ssc_pkg::CTRL_BUZ_SUB] && !ctrl_q[ssc_pkg::CTRL_RTC_LP]))
    |=> !PERIPH.buzzer_en)
    else $error("buzzer running in sleep");
  a_snooze_entry: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_STOP && !IRQ_PENDING && !ADDR_MATCH && SNOOZE_TRIG
     && ctrl_q[ssc_pkg::CTRL_CONV_SNZ]) |=> state_q == ssc_pkg::SSC_SNOOZE)
    else $error("converter trigger did not enter partial wake");
  a_snooze_return: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_SNOOZE && !IRQ_PENDING && !SNOOZE_TRIG)
    |=> state_q == ssc_pkg::SSC_STOP)
    else $error("partial wake did not fall back to sleep");
  a_serial_others: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q != ssc_pkg::SSC_RUN)
    |=> !PERIPH.ser_other_en)
    else $error("other serial channels enabled in sleep");
  a_match_wakes: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_STOP && ADDR_MATCH)
    |=> state_q == ssc_pkg::SSC_CLKOFF)
    else $error("address match did not end sleep");
  a_two_wire_armed: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_STOP)
    |=> PERIPH.two_wire_wake_en)
    else $error("two-wire wake not armed in sleep");
  a_auto_stop: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q != ssc_pkg::SSC_RUN)
    |=> PERIPH.auto_stop)
    else $error("stopped functions not halted in sleep");

  // wake timing and reset release
  a_vec_resume: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_WAIT && wait_q == 4'h1 && vec_q)
    |=> RESUME_VEC && state_q == ssc_pkg::SSC_RUN)
    else $error("vectored resume missing");
  a_next_resume: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (CLK_EN && state_q == ssc_pkg::SSC_WAIT && wait_q == 4'h1 && !vec_q)
    |=> RESUME_NEXT && !RESUME_VEC)
    else $error("resume after sleep instruction missing");
  a_hoco_wait: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_q == ssc_pkg::SSC_CLKOFF) ##1 (state_q == ssc_pkg::SSC_WAIT && !x1_q && vec_q)
    |-> wait_q == ssc_pkg::WAIT_HOCO_VEC)
    else $error("internal oscillator wait count wrong");
  a_x1_wait: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_q == ssc_pkg::SSC_CLKOFF) ##1 (state_q == ssc_pkg::SSC_WAIT && x1_q && !vec_q)
    |-> wait_q == ssc_pkg::WAIT_X1_NOVEC)
    else $error("crystal wait count wrong");
  a_min_clkoff: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_q == ssc_pkg::SSC_CLKOFF && {1'b0, cnt_q} + 17'h00001 < {1'b0, off_len_q})
    |=> state_q == ssc_pkg::SSC_CLKOFF)
    else $error("clock-off ended before the minimum");
  a_x1_clkoff: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    (state_q == ssc_pkg::SSC_CLKOFF && x1_q && {1'b0, cnt_q} + 17'h00001 < {1'b0, osc_stab_time_select_q})
    |=> state_q == ssc_pkg::SSC_CLKOFF)
    else $error("crystal clock-off shorter than stabilization");
  a_reset_run: assert property (@(posedge CORE_CLK)
    SYS_RST
    |=> state_q == ssc_pkg::SSC_RUN && !SLEEPING && CLK_GATES.cpu_clk_en)
    else $error("reset did not end sleep");
endmodule
`default_nettype wire

// ---- ssc_pkg.sv ----
// package: constants and carrier types for the stop mode standby controller
`default_nettype none
package ssc_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CLK_OFF_MIN_US = 18;
  localparam int unsigned CLK_OFF_MAX_US = 105;
  // least time rounds up; the cycle count comes from the rate
  localparam int unsigned CLK_OFF_MIN_CYC = CLK_OFF_MIN_US * CLK_MHZ;
  localparam int unsigned CLK_OFF_MAX_CYC = CLK_OFF_MAX_US * CLK_MHZ;
  localparam int unsigned CNT_W = 16;
  localparam logic [3:0] WAIT_HOCO_VEC = 4'h7;
  localparam logic [3:0] WAIT_HOCO_NOVEC = 4'h1;
  localparam logic [3:0] WAIT_X1_VEC = 4'hA;
  localparam logic [3:0] WAIT_X1_NOVEC = 4'h4;
  // clock source codes
  localparam logic [2:0] SRC_HOCO = 3'h0;
  localparam logic [2:0] SRC_X1 = 3'h1;
  localparam logic [2:0] SRC_EXT = 3'h2;
  localparam logic [2:0] SRC_PLL = 3'h3;
  localparam logic [2:0] SRC_SUB = 3'h4;
  // wishbone register map, byte addresses
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_OSC_STAB_TIME_SELECT = 4'h8;
  // control register fields
  localparam int unsigned CTRL_PLL_STOP = 0;
  localparam int unsigned CTRL_WUT_CLK = 1;
  localparam int unsigned CTRL_WDT_EN = 2;
  localparam int unsigned CTRL_WDT_STBY = 3;
  localparam int unsigned CTRL_RTC_LP = 4;
  localparam int unsigned CTRL_BUZ_SUB = 5;
  localparam int unsigned CTRL_CONV_SNZ = 6;
  localparam int unsigned CTRL_SER_SNZ = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [CNT_W-1:0] OSC_STAB_TIME_SELECT_RST = 16'h5000;

  typedef enum logic [2:0] {
    SSC_RUN = 3'b000,
    SSC_STOP = 3'b001,
    SSC_CLKOFF = 3'b011,
    SSC_WAIT = 3'b010,
    SSC_SNOOZE = 3'b110
  } ssc_state_t;

  // clock gates driven to the clock generator
  typedef struct packed {
    logic cpu_clk_en;
    logic hoco_en;
    logic x1_en;
    logic ext_en;
    logic pll_en;
    logic lowspeed_en;
  } ssc_clk_t;

  // peripheral enables while asleep
  typedef struct packed {
    logic buzzer_en;
    logic conv_wake_en;
    logic ser_ch0_wake_en;
    logic ser_other_en;
    logic two_wire_wake_en;
    logic latch_hold;
    logic auto_stop;
  } ssc_periph_t;
endpackage
`default_nettype wire

// ---- ssc_cpu_model.sv ----
// cpu core and interrupt controller model facing the standby controller
`timescale 1ns/100ps
`default_nettype none
module ssc_cpu_model (
  input wire logic clk, // core clock
  input wire logic resume, // either resume pulse from the controller
  output logic sleep_req, // sleep instruction strobe
  output logic [2:0] src, // cpu clock source
  output logic irq, // some unmasked request flag set
  output logic ack_en // interrupt acknowledge enabled
);
  initial begin
    sleep_req = 1'b0;
    src = ssc_pkg::SRC_HOCO;
    irq = 1'b0;
    ack_en = 1'b0;
  end
  // call just after a rising edge; strobe stands exactly one cycle
  task automatic exec_sleep(input logic [2:0] s, input logic a);
    src <= s;
    ack_en <= a;
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
  endtask
  task automatic raise_irq;
    irq <= 1'b1;
  endtask
  // request flag drops only once the cpu has resumed
  always @(posedge clk) begin
    if (resume === 1'b1) irq <= 1'b0;
  end
endmodule
`default_nettype wire

// ---- ssc_ctrl_bench.sv ----
// self-checking bench for the stop mode standby controller
`timescale 1ns/100ps
`default_nettype none
module ssc_ctrl_bench;
  logic clk, rst, snz, adm, we, cyc, ack, slp, rvec, rnext, sreq, irq, aen, cen;
  logic [3:0] sel, lanes;
  logic [31:0] adr, wdat, rdat, q;
  logic [2:0] src;
  ssc_pkg::ssc_clk_t gates;
  ssc_pkg::ssc_periph_t per;
  int miscompares;
  int checks_done;
  ssc_ctrl i_ssc_ctrl (.CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(cen), .SLEEP_REQ(sreq), .CPU_CLK_SRC(src),
    .IRQ_PENDING(irq), .IRQ_ACK_EN(aen), .SNOOZE_TRIG(snz), .ADDR_MATCH(adm), .WB_ADR_I(adr),
    .WB_DAT_I(wdat), .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .CLK_GATES(gates), .PERIPH(per), .SLEEPING(slp), .RESUME_VEC(rvec), .RESUME_NEXT(rnext));
  ssc_cpu_model i_ssc_cpu_model (.clk(clk), .resume(rvec | rnext), .sleep_req(sreq), .src(src), .irq(irq),
    .ack_en(aen));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; ack and read data are taken at the same edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    sel <= lanes;
    we <= w;
    adr <= {28'h0, a};
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    sel <= 4'h0;
    we <= 1'b0;
    if (k >= 50) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic sleep(input logic [2:0] s, input logic a, input logic exp);
    @(posedge clk);
    i_ssc_cpu_model.exec_sleep(s, a);
    repeat (4) @(posedge clk);
    chk("sleeping", {31'h0, exp}, {31'h0, slp});
    chk("cpu clock", {31'h0, !exp}, {31'h0, gates.cpu_clk_en});
  endtask
  // how: 0 interrupt, 1 address match, 2 already pending
  task automatic wake(input int how, input logic vec, input int lo, input int hi);
    int k;
    @(posedge clk);
    if (how == 1) adm <= 1'b1;
    if (how == 0) i_ssc_cpu_model.raise_irq();
    k = 0;
    do begin
      @(posedge clk);
      adm <= 1'b0;
      k++;
    end while (rvec !== 1'b1 && rnext !== 1'b1 && k < hi);
    chk("resume vec", {31'h0, vec}, {31'h0, rvec});
    chk("resume next", {31'h0, !vec}, {31'h0, rnext});
    chk("wake cycles in range", 32'h1, {31'h0, k >= lo && k < hi});
    if (k >= hi) report_and_stop();
    repeat (2) @(posedge clk);
    chk("awake", 32'h0, {31'h0, slp});
    chk("gates on", 32'h3C, {26'h0, gates} & 32'h3E);
  endtask
  task automatic t_reset;
    chk("gates at reset", 32'h3F, {26'h0, gates});
    chk("periph at reset", 32'h0, {25'h0, per});
    wb(1'b0, ssc_pkg::ADR_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, q);
    wb(1'b0, ssc_pkg::ADR_OSC_STAB_TIME_SELECT, 32'h0);
    chk("osc_stab_time_select reset", 32'h5000, q);
    lanes = 4'h1;
    wb(1'b1, ssc_pkg::ADR_OSC_STAB_TIME_SELECT, 32'h0000_FFFF);
    lanes = 4'hF;
    wb(1'b0, ssc_pkg::ADR_OSC_STAB_TIME_SELECT, 32'h0);
    chk("osc_stab_time_select low lane only", 32'h50FF, q);
    wb(1'b1, 4'hC, 32'hFFFF_FFFF);
    wb(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_refuse;
    sleep(ssc_pkg::SRC_HOCO, 1'b1, 1'b0);
    wb(1'b1, ssc_pkg::ADR_CTRL, 32'h1);
    sleep(ssc_pkg::SRC_PLL, 1'b1, 1'b0);
    sleep(ssc_pkg::SRC_SUB, 1'b1, 1'b0);
  endtask
  task automatic t_hoco;
    wb(1'b1, ssc_pkg::ADR_CTRL, 32'h63);
    sleep(ssc_pkg::SRC_HOCO, 1'b1, 1'b1);
    chk("gates asleep", 32'h01, {26'h0, gates});
    chk("periph asleep", 32'h67, {25'h0, per});
    wb(1'b0, ssc_pkg::ADR_STAT, 32'h0);
    chk("state stop", 32'h1, q & 32'h7);
    snz <= 1'b1;
    wb(1'b0, ssc_pkg::ADR_STAT, 32'h0);
    chk("state snooze", 32'h6, q & 32'h7);
    chk("hoco in snooze", 32'h1, {31'h0, gates.hoco_en});
    snz <= 1'b0;
    wb(1'b0, ssc_pkg::ADR_STAT, 32'h0);
    chk("back to stop", 32'h1, q & 32'h7);
    chk("hoco off in stop", 32'h0, {31'h0, gates.hoco_en});
    wake(0, 1'b1, ssc_pkg::CLK_OFF_MIN_CYC + 7, ssc_pkg::CLK_OFF_MAX_CYC + 12);
  endtask
  task automatic t_x1;
    wb(1'b1, ssc_pkg::ADR_OSC_STAB_TIME_SELECT, 32'h1F40);
    wb(1'b1, ssc_pkg::ADR_CTRL, 32'h09);
    sleep(ssc_pkg::SRC_X1, 1'b0, 1'b1);
    chk("x1 gates asleep", 32'h00, {26'h0, gates});
    wake(0, 1'b0, 32'h1F40 + 4, 32'h1F40 + 16);
  endtask
  task automatic t_misc;
    @(posedge clk);
    i_ssc_cpu_model.raise_irq();
    sleep(ssc_pkg::SRC_EXT, 1'b1, 1'b1);
    wake(2, 1'b1, ssc_pkg::CLK_OFF_MIN_CYC + 3, ssc_pkg::CLK_OFF_MAX_CYC + 12);
    sleep(ssc_pkg::SRC_HOCO, 1'b1, 1'b1);
    wake(1, 1'b1, ssc_pkg::CLK_OFF_MIN_CYC + 7, ssc_pkg::CLK_OFF_MAX_CYC + 12);
    sleep(ssc_pkg::SRC_HOCO, 1'b0, 1'b1);
    // enable low: a match during the freeze must be ignored
    cen <= 1'b0;
    adm <= 1'b1;
    repeat (3) @(posedge clk);
    cen <= 1'b1;
    adm <= 1'b0;
    @(posedge clk);
    chk("frozen ignores match", 32'h1, {31'h0, slp});
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("sleep ended by reset", 32'h0, {31'h0, slp});
    chk("gates after reset", 32'h3F, {26'h0, gates});
  endtask
  initial begin
    rst = 1'b1;
    snz = 1'b0;
    adm = 1'b0;
    we = 1'b0;
    cyc = 1'b0;
    cen = 1'b1;
    sel = 4'h0;
    lanes = 4'hF;
    adr = 32'h0;
    wdat = 32'h0;
    miscompares = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_refuse();
    t_hoco();
    t_x1();
    t_misc();
    report_and_stop();
  end
endmodule
`default_nettype wire
